// *** pkg/vca_defines.vh ***
// register map, reset values and scaling constants of the colour adjust stage
`ifndef VCA_DEFINES_VH
`define VCA_DEFINES_VH

// register byte offsets
`define VCA_OFS_CTRL_EVEN 12'h02c
`define VCA_OFS_LUMA_LO 12'h030
`define VCA_OFS_U_LO 12'h034
`define VCA_OFS_V_LO 12'h038
`define VCA_OFS_HUE 12'h03c
`define VCA_OFS_CTRL_ODD 12'h0ac
`define VCA_OFS_STATUS 12'h0f0

// reset values
`define VCA_RST_LUMA_LO 8'hd8
`define VCA_RST_U_LO 8'hfe
`define VCA_RST_V_LO 8'hb4
`define VCA_RST_HUE 8'h00
`define VCA_RST_CTRL 8'h20

// control register fields
`define VCA_CTRL_LUMA_TOP 2
`define VCA_CTRL_U_TOP 1
`define VCA_CTRL_V_TOP 0
`define VCA_CTRL_RSVD 3
`define VCA_CTRL_WMASK 8'hf7

// unity gain codes
`define VCA_UNITY_LUMA 216
`define VCA_UNITY_U 254
`define VCA_UNITY_V 180

// fixed point shift of the reciprocal of unity gain
`define VCA_SCALE_SHIFT 20

`endif

// *** core/vca_gain_scale.v ***
// one gain stage: sample times 9-bit gain over unity code, clipped
`timescale 1ns/10ps
`default_nettype none

`include "vca_defines.vh"

module vca_gain_scale #(
  parameter UNITY = 216,
  parameter SIGNED_IN = 0
) (
  // clock and reset
  input wire clk_i,
  input wire reset_i,
  // sample and gain
  input wire [7:0] sample_i,
  input wire [8:0] gain_i,
  // result
  output reg [7:0] sample_o,
  output reg clip_o
);

  localparam [31:0] RECIP =
    ((32'h1 << `VCA_SCALE_SHIFT) + UNITY / 2) / UNITY;
  localparam [31:0] HALF = 32'h1 << (`VCA_SCALE_SHIFT - 1);

  wire neg;
  wire [7:0] mag;
  wire [16:0] prod;
  wire [31:0] scaled;
  wire [31:0] quot;
  reg [7:0] sample_next;
  reg clip_next;

  // signed samples are scaled as magnitude, sign restored after
  assign neg = (SIGNED_IN != 0) && sample_i[7];
  assign mag = neg ? (8'h00 - sample_i) : sample_i;
  assign prod = {9'h000, mag} * {8'h00, gain_i};
  assign scaled = {15'h0000, prod} * RECIP;
  assign quot = (scaled + HALF) >> `VCA_SCALE_SHIFT;

  always @* begin
    sample_next = quot[7:0];
    clip_next = 1'b0;
    if (SIGNED_IN == 0) begin
      if (quot > 32'd255) begin
        sample_next = 8'hff;
        clip_next = 1'b1;
      end
    end else if (neg) begin
      if (quot > 32'd128) begin
        sample_next = 8'h80;
        clip_next = 1'b1;
      end else begin
        sample_next = 8'h00 - quot[7:0];
      end
    end else if (quot > 32'd127) begin
      sample_next = 8'h7f;
      clip_next = 1'b1;
    end
  end

  always @(posedge clk_i or posedge reset_i) begin
    if (reset_i) begin
      sample_o <= 8'h00;
      clip_o <= 1'b0;
    end else begin
      sample_o <= sample_next;
      clip_o <= clip_next;
    end
  end

endmodule

`default_nettype wire

// *** core/vca_hue_shift.v ***
// adds the signed hue offset to the demodulating subcarrier phase
`timescale 1ns/10ps
`default_nettype none

module vca_hue_shift #(
  parameter PHASE_W = 9
) (
  // clock and reset
  input wire clk_i,
  input wire reset_i,
  // phase in and offset
  input wire [PHASE_W-1:0] phase_i,
  input wire [7:0] hue_i,
  // shifted phase
  output reg [PHASE_W-1:0] phase_o
);

  // one phase step is 180/256 degree, phase wraps at a full turn
  wire [PHASE_W-1:0] hue_ext;

  assign hue_ext = {{(PHASE_W-8){hue_i[7]}}, hue_i};

  always @(posedge clk_i or posedge reset_i) begin
    if (reset_i) begin
      phase_o <= {PHASE_W{1'b0}};
    end else begin
      phase_o <= phase_i + hue_ext;
    end
  end

endmodule

`default_nettype wire

// *** core/vca_top.v ***
// colour adjust stage: contrast, saturation and hue with apb registers
//
// The APB slave port is this design's own decision.
`timescale 1ns/10ps
`default_nettype none

`include "vca_defines.vh"

// Notes on behaviour
// - luma gain is nine bits unsigned, top bit above the low byte.
// - luma sample times gain; 216 is unity, 511 about 236.57 percent.
// - luma gain low byte resets to 0xd8, unity contrast.
// - U times nine-bit gain; 254 unity, 511 about 201.18 percent.
// - U gain low byte resets to 0xfe, unity gain.
// - V times nine-bit gain; 180 unity, 511 about 283.89 percent.
// - V gain low byte resets to 0xb4, unity gain.
// - signed hue added to subcarrier phase, 0.7 degree steps.
// - hue register resets to 0x00, no phase offset.
// - gain top bits from control bits 2,1,0, per field copy.
module vca_top #(
  parameter PHASE_W = 9
) (
  // clock and reset
  input wire clk_i,
  input wire reset_i,
  // apb slave
  input wire [11:0] paddr_i,
  input wire psel_i,
  input wire penable_i,
  input wire pwrite_i,
  input wire [31:0] pwdata_i,
  output reg [31:0] prdata_o,
  output wire pready_o,
  output reg pslverr_o,
  // pixel stream in
  input wire pix_valid_i,
  input wire field_odd_i,
  input wire [7:0] luma_i,
  input wire [7:0] chroma_u_i,
  input wire [7:0] chroma_v_i,
  input wire [PHASE_W-1:0] sc_phase_i,
  // pixel stream out
  output reg pix_valid_o,
  output reg field_odd_o,
  output wire [7:0] luma_o,
  output wire [7:0] chroma_u_o,
  output wire [7:0] chroma_v_o,
  output wire [PHASE_W-1:0] sc_phase_o
);

  // register storage
  reg [7:0] luma_gain_low_byte_reg;
  reg [7:0] u_gain_low_byte_reg;
  reg [7:0] v_gain_low_byte_reg;
  reg [7:0] hue_phase_offset_reg;
  reg [7:0] ctrl_even_reg;
  reg [7:0] ctrl_odd_reg;
  reg [2:0] clip_seen_reg;
  reg [2:0] clip_seen_next;

  // bus decode
  wire setup_phase;
  wire access_phase;
  wire wr_en;
  reg [31:0] rd_next;
  reg err_next;

  // gain datapath
  wire [7:0] ctrl_sel;
  wire [8:0] luma_gain;
  wire [8:0] u_gain;
  wire [8:0] v_gain;
  wire clip_luma;
  wire clip_u;
  wire clip_v;

  // address decode used by both read and write paths
  function is_mapped;
    input [11:0] addr;
    begin
      case (addr)
        `VCA_OFS_CTRL_EVEN: is_mapped = 1'b1;
        `VCA_OFS_LUMA_LO: is_mapped = 1'b1;
        `VCA_OFS_U_LO: is_mapped = 1'b1;
        `VCA_OFS_V_LO: is_mapped = 1'b1;
        `VCA_OFS_HUE: is_mapped = 1'b1;
        `VCA_OFS_CTRL_ODD: is_mapped = 1'b1;
        `VCA_OFS_STATUS: is_mapped = 1'b1;
        default: is_mapped = 1'b0;
      endcase
    end
  endfunction

  assign setup_phase = psel_i && !penable_i;
  assign access_phase = psel_i && penable_i;
  // no wait states; read data is captured in the setup cycle
  assign pready_o = 1'b1;
  assign wr_en = access_phase && pwrite_i && is_mapped(paddr_i);

  // read mux, reserved bits read as zero
  always @* begin
    rd_next = 32'h0000_0000;
    case (paddr_i)
      `VCA_OFS_CTRL_EVEN: begin
        rd_next[7:0] = ctrl_even_reg;
      end
      `VCA_OFS_CTRL_ODD: begin
        rd_next[7:0] = ctrl_odd_reg;
      end
      `VCA_OFS_LUMA_LO: begin
        rd_next[7:0] = luma_gain_low_byte_reg;
      end
      `VCA_OFS_U_LO: begin
        rd_next[7:0] = u_gain_low_byte_reg;
      end
      `VCA_OFS_V_LO: begin
        rd_next[7:0] = v_gain_low_byte_reg;
      end
      `VCA_OFS_HUE: begin
        rd_next[7:0] = hue_phase_offset_reg;
      end
      `VCA_OFS_STATUS: begin
        rd_next[3:0] = {clip_seen_reg, field_odd_o};
      end
      default: begin
        rd_next = 32'h0000_0000;
      end
    endcase
    err_next = !is_mapped(paddr_i);
  end

  always @(posedge clk_i or posedge reset_i) begin
    if (reset_i) begin
      prdata_o <= 32'h0000_0000;
      pslverr_o <= 1'b0;
    end else if (setup_phase) begin
      prdata_o <= pwrite_i ? 32'h0000_0000 : rd_next;
      pslverr_o <= err_next;
    end else if (!psel_i) begin
      prdata_o <= 32'h0000_0000;
      pslverr_o <= 1'b0;
    end
  end

  // register writes
  always @(posedge clk_i or posedge reset_i) begin
    if (reset_i) begin
      luma_gain_low_byte_reg <= `VCA_RST_LUMA_LO;
      u_gain_low_byte_reg <= `VCA_RST_U_LO;
      v_gain_low_byte_reg <= `VCA_RST_V_LO;
      hue_phase_offset_reg <= `VCA_RST_HUE;
      ctrl_even_reg <= `VCA_RST_CTRL;
      ctrl_odd_reg <= `VCA_RST_CTRL;
    end else if (wr_en) begin
      case (paddr_i)
        `VCA_OFS_LUMA_LO: begin
          luma_gain_low_byte_reg <= pwdata_i[7:0];
        end
        `VCA_OFS_U_LO: begin
          u_gain_low_byte_reg <= pwdata_i[7:0];
        end
        `VCA_OFS_V_LO: begin
          v_gain_low_byte_reg <= pwdata_i[7:0];
        end
        `VCA_OFS_HUE: begin
          hue_phase_offset_reg <= pwdata_i[7:0];
        end
        `VCA_OFS_CTRL_EVEN: begin
          ctrl_even_reg <= pwdata_i[7:0] & `VCA_CTRL_WMASK;
        end
        `VCA_OFS_CTRL_ODD: begin
          ctrl_odd_reg <= pwdata_i[7:0] & `VCA_CTRL_WMASK;
        end
        default: begin
          ctrl_odd_reg <= ctrl_odd_reg;
        end
      endcase
    end
  end

  // top gain bits follow the field of the incoming pixel
  assign ctrl_sel = field_odd_i ? ctrl_odd_reg : ctrl_even_reg;
  assign luma_gain = {ctrl_sel[`VCA_CTRL_LUMA_TOP],
                      luma_gain_low_byte_reg};
  assign u_gain = {ctrl_sel[`VCA_CTRL_U_TOP], u_gain_low_byte_reg};
  assign v_gain = {ctrl_sel[`VCA_CTRL_V_TOP], v_gain_low_byte_reg};

  // contrast
  vca_gain_scale #(
    .UNITY(`VCA_UNITY_LUMA),
    .SIGNED_IN(0)
  ) u_luma_scale (
    .clk_i(clk_i),
    .reset_i(reset_i),
    .sample_i(luma_i),
    .gain_i(luma_gain),
    .sample_o(luma_o),
    .clip_o(clip_luma)
  );

  // saturation, U
  vca_gain_scale #(
    .UNITY(`VCA_UNITY_U),
    .SIGNED_IN(1)
  ) u_u_scale (
    .clk_i(clk_i),
    .reset_i(reset_i),
    .sample_i(chroma_u_i),
    .gain_i(u_gain),
    .sample_o(chroma_u_o),
    .clip_o(clip_u)
  );

  // saturation, V
  vca_gain_scale #(
    .UNITY(`VCA_UNITY_V),
    .SIGNED_IN(1)
  ) u_v_scale (
    .clk_i(clk_i),
    .reset_i(reset_i),
    .sample_i(chroma_v_i),
    .gain_i(v_gain),
    .sample_o(chroma_v_o),
    .clip_o(clip_v)
  );

  // reference phase moves with the register, displayed hue the other way
  vca_hue_shift #(
    .PHASE_W(PHASE_W)
  ) u_hue_shift (
    .clk_i(clk_i),
    .reset_i(reset_i),
    .phase_i(sc_phase_i),
    .hue_i(hue_phase_offset_reg),
    .phase_o(sc_phase_o)
  );

  // sticky clip flags; a write of ones clears, a new clip wins
  always @* begin
    clip_seen_next = clip_seen_reg;
    if (wr_en && (paddr_i == `VCA_OFS_STATUS)) begin
      clip_seen_next = clip_seen_reg & ~pwdata_i[3:1];
    end
    if (pix_valid_o) begin
      clip_seen_next = clip_seen_next | {clip_v, clip_u, clip_luma};
    end
  end

  // stream control, one cycle latency like the datapath
  always @(posedge clk_i or posedge reset_i) begin
    if (reset_i) begin
      pix_valid_o <= 1'b0;
      field_odd_o <= 1'b0;
      clip_seen_reg <= 3'h0;
    end else begin
      pix_valid_o <= pix_valid_i;
      field_odd_o <= field_odd_i;
      clip_seen_reg <= clip_seen_next;
    end
  end

endmodule

`default_nettype wire

// *** testbench/vca_top_assertions.sv ***
// assertions on the ports of the colour adjust stage
`timescale 1ns/10ps
`default_nettype none
module vca_top_assertions #(
  parameter PHASE_W = 9
) (
  // clock, reset and apb
  input wire logic clk_i,
  input wire logic reset_i,
  input wire logic [11:0] paddr_i,
  input wire logic psel_i,
  input wire logic penable_i,
  input wire logic pwrite_i,
  input wire logic [31:0] pwdata_i,
  input wire logic [31:0] prdata_o,
  input wire logic pready_o,
  // stream
  input wire logic [7:0] luma_i,
  input wire logic [7:0] chroma_u_i,
  input wire logic [7:0] chroma_v_i,
  input wire logic [PHASE_W-1:0] sc_phase_i,
  input wire logic [7:0] luma_o,
  input wire logic [7:0] chroma_u_o,
  input wire logic [7:0] chroma_v_o,
  input wire logic [PHASE_W-1:0] sc_phase_o
);
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (reset_i);
  logic [7:0] sh [0:3];
  logic [PHASE_W-1:0] ph_exp;
  wire acc = psel_i && penable_i && pready_o;
  wire hit = paddr_i[11:4] == 8'h03 && paddr_i[1:0] == 2'b00;
  wire rd = acc && !pwrite_i && hit;
  // shadow copies of the gain and hue registers
  always_ff @(posedge clk_i or posedge reset_i) begin
    if (reset_i) begin
      sh[0] <= 8'hd8;
      sh[1] <= 8'hfe;
      sh[2] <= 8'hb4;
      sh[3] <= 8'h00;
      ph_exp <= '0;
    end else begin
      ph_exp <= sc_phase_i + {{(PHASE_W-8){sh[3][7]}}, sh[3]};
      if (acc && pwrite_i && hit) begin
        sh[paddr_i[3:2]] <= pwdata_i[7:0];
      end
    end
  end
  chk_luma_read: assert property (rd && paddr_i[3:2] == 2'd0 |->
    prdata_o == {24'h0, sh[0]}) else $error("luma gain readback");
  chk_u_read: assert property (rd && paddr_i[3:2] == 2'd1 |->
    prdata_o == {24'h0, sh[1]}) else $error("u gain readback");
  chk_v_read: assert property (rd && paddr_i[3:2] == 2'd2 |->
    prdata_o == {24'h0, sh[2]}) else $error("v gain readback");
  chk_hue_read: assert property (rd && paddr_i[3:2] == 2'd3 |->
    prdata_o == {24'h0, sh[3]}) else $error("hue readback");
  chk_phase_add: assert property (!$past(reset_i) |->
    sc_phase_o == ph_exp) else $error("phase offset wrong");
  chk_luma_zero: assert property (!$past(reset_i)
    && $past(luma_i) == 8'h00 |-> luma_o == 8'h00)
    else $error("zero luma not zero");
  chk_u_zero: assert property (!$past(reset_i)
    && $past(chroma_u_i) == 8'h00 |-> chroma_u_o == 8'h00)
    else $error("zero u not zero");
  chk_u_no_wrap: assert property (!$past(reset_i)
    && $past(chroma_u_i[7]) |-> chroma_u_o[7] || chroma_u_o == 8'h00)
    else $error("u wrapped");
  chk_v_no_wrap: assert property (!$past(reset_i)
    && !$past(chroma_v_i[7]) |-> !chroma_v_o[7])
    else $error("v wrapped");
  cover property (acc && pwrite_i && hit);
  cover property (luma_o == 8'hff);
  cover property (acc && !hit);
endmodule
bind vca_top vca_top_assertions #(.PHASE_W(PHASE_W)) u_chk (.*);
`default_nettype wire

// *** testbench/tb_top.sv ***
// self-checking bench for the colour adjust stage
`timescale 1ns/10ps
`default_nettype none
module tb_top;
  logic clk_i = 0, reset_i = 1, psel_i = 0, penable_i = 0, pwrite_i = 0;
  logic pix_valid_i = 0, field_odd_i = 0, pready_o, pslverr_o;
  logic pix_valid_o, field_odd_o, e;
  logic [11:0] paddr_i = 0;
  logic [31:0] pwdata_i = 0, prdata_o, r;
  logic [7:0] luma_i = 0, chroma_u_i = 0, chroma_v_i = 0;
  logic [7:0] luma_o, chroma_u_o, chroma_v_o;
  logic [8:0] sc_phase_i = 0, sc_phase_o;
  logic [7:0] lo [0:3];
  logic [2:0] top [0:1];
  logic [2:0] tp;
  logic [7:0] xl, xu, xv;
  logic [8:0] pe;
  integer seed = 3, mismatches = 0, cmp_count = 0, t, s;
  vca_top u_dut (.*);
  initial begin
    forever #20 clk_i = ~clk_i;
  end
  function automatic [7:0] f_luma(input [7:0] y, input [8:0] g);
    reg [31:0] q;
    begin
      q = (y * g * 4855 + 32'h80000) >> 20;
      f_luma = q > 255 ? 8'hff : q[7:0];
    end
  endfunction
  function automatic [7:0] f_chr(input [7:0] c, input [8:0] g, input int k);
    reg [31:0] m, q;
    begin
      m = c[7] ? 256 - c : c;
      q = (m * g * k + 32'h80000) >> 20;
      if (!c[7]) f_chr = q > 127 ? 8'h7f : q[7:0];
      else f_chr = q > 128 ? 8'h80 : 8'h00 - q[7:0];
    end
  endfunction
  task automatic check(input [31:0] seen, input [31:0] exp);
    begin
      cmp_count++;
      if (seen !== exp) begin
        mismatches++;
        $display("CHECK FAILED at %0t: seen %h expected %h", $time, seen, exp);
      end
    end
  endtask
  task automatic apb(input [11:0] a, input wr, input [7:0] d);
    begin
      psel_i <= 1;
      paddr_i <= a;
      pwrite_i <= wr;
      pwdata_i <= {24'h0, d};
      @(posedge clk_i);
      penable_i <= 1;
      @(posedge clk_i);
      while (pready_o !== 1'b1) @(posedge clk_i);
      r = prdata_o;
      e = pslverr_o;
      psel_i <= 0;
      penable_i <= 0;
      @(posedge clk_i);
    end
  endtask
  task summarize;
    begin
      $display("compares %0d mismatches %0d", cmp_count, mismatches);
      if (mismatches == 0 && cmp_count > 0) $display("ALL CHECKS OK");
      else $display("CHECKS NOT OK");
      $finish;
    end
  endtask
  initial begin
    #(40 * 5000);
    mismatches++;
    summarize;
  end
  initial begin
    repeat (2) @(posedge clk_i);
    reset_i <= 0;
    @(posedge clk_i);
    lo = '{8'hd8, 8'hfe, 8'hb4, 8'h00};
    for (s = 0; s < 4; s++) begin
      apb(12'h030 + 4 * s, 0, 0);
      check(r, lo[s]);
    end
    apb(12'h0ac, 0, 0);
    check(r, 8'h20);
    apb(12'h100, 0, 0);
    check(r, 32'h0);
    check(e, 1'b1);
    $display("test reset values done");
    for (t = 0; t < 12; t++) begin
      for (s = 0; s < 4; s++) begin
        lo[s] = t == 0 ? 8'h00 : t == 1 ? 8'hff : $random(seed);
        if (s == 3 && t < 4) lo[s] = t == 2 ? 8'h80 : 8'h7f;
        apb(12'h030 + 4 * s, 1, lo[s]);
        apb(12'h030 + 4 * s, 0, 0);
        check(r, lo[s]);
      end
      top[0] = t == 0 ? 3'h0 : t == 1 ? 3'h7 : $random(seed);
      top[1] = t == 0 ? 3'h0 : $random(seed);
      apb(12'h02c, 1, {5'h04, top[0]});
      apb(12'h0ac, 1, {5'h04, top[1]});
      for (s = 0; s < 8; s++) begin
        pix_valid_i <= $random(seed);
        field_odd_i <= $random(seed);
        luma_i <= s == 0 ? 8'hff : $random(seed);
        chroma_u_i <= s == 0 ? 8'h80 : $random(seed);
        chroma_v_i <= s == 0 ? 8'h7f : $random(seed);
        sc_phase_i <= $random(seed);
        @(posedge clk_i);
        #1;
        tp = top[field_odd_i];
        xl = f_luma(luma_i, {tp[2], lo[0]});
        xu = f_chr(chroma_u_i, {tp[1], lo[1]}, 4128);
        xv = f_chr(chroma_v_i, {tp[0], lo[2]}, 5825);
        pe = sc_phase_i + {lo[3][7], lo[3]};
        check(luma_o, xl);
        check(chroma_u_o, xu);
        check(chroma_v_o, xv);
        check(sc_phase_o, pe);
        check({pix_valid_o, field_odd_o}, {pix_valid_i, field_odd_i});
        @(posedge clk_i);
      end
      $display("test %0d done", t);
    end
    // reserved control bit, doubled U and V gains, clipping, sticky flags
    apb(12'h02c, 1, 8'h2f);
    apb(12'h02c, 0, 0);
    check(r, 8'h27);
    apb(12'h030, 1, 8'hff);
    apb(12'h034, 1, 8'hfc);
    apb(12'h038, 1, 8'h68);
    pix_valid_i <= 1;
    field_odd_i <= 0;
    luma_i <= 8'hff;
    chroma_u_i <= 8'h20;
    chroma_v_i <= 8'hf0;
    @(posedge clk_i);
    #1;
    check(chroma_u_o, 8'h40);
    check(chroma_v_o, 8'he0);
    check(luma_o, 8'hff);
    @(posedge clk_i);
    chroma_u_i <= 8'h7f;
    chroma_v_i <= 8'h80;
    @(posedge clk_i);
    #1;
    check(chroma_u_o, 8'h7f);
    check(chroma_v_o, 8'h80);
    @(posedge clk_i);
    pix_valid_i <= 0;
    apb(12'h0f0, 0, 0);
    check(r, 32'he);
    apb(12'h0f0, 1, 8'h0e);
    apb(12'h0f0, 0, 0);
    check(r, 32'h0);
    $display("test clip and status done");
    summarize;
  end
endmodule
`default_nettype wire
